// ==== src/srmc_ctrl.sv ====
// Purpose: Host controller driving an asynchronous 128K x 8 static RAM
// Assumes: One request at a time; RAM pins on the same board clock
// Notes: Read data sampled at the end of the access window
`timescale 1ns/1ns
`include "srmc_params.svh"

// Function
// - Select plus strobe low stores data
// - Select, output enable low, strobe high reads
// - Setup and hold from ending edge
// - Write cycle covers highz plus setup
// - Host never drives while device drives
// - Address valid by select falling edge
module srmc_ctrl #(
  parameter int WR_CYC = `SRMC_WR_CYC,
  parameter int RD_CYC = `SRMC_RD_CYC
) (
  input wire logic CLK, // System clock
  input wire logic RST_N, // Async reset, low
  input wire logic REQ_VALID, // Request offered
  output logic REQ_READY, // Request taken this cycle
  input wire srmc_pkg::srmc_req_t REQ, // Request fields
  output logic RSP_VALID, // One-cycle done pulse
  output logic [`SRMC_DATA_W-1:0] RSP_RDATA, // Read data
  output logic [`SRMC_ADDR_W-1:0] MEM_ADDR, // RAM address
  output logic MEM_CE_N, // RAM chip select
  output logic MEM_OE_N, // RAM output enable
  output logic MEM_WE_N, // RAM write strobe
  input wire logic [`SRMC_DATA_W-1:0] MEM_DQ_I, // Data from pins
  output logic [`SRMC_DATA_W-1:0] MEM_DQ_O, // Data to pins
  output logic MEM_DQ_OE // High while host drives data
);

  // ****************************************
  // Parameter checks
  // ****************************************
  // Sync stages plus the agreement register
  localparam int SYNC_LAT = 4;

  // Waits count in eight bits; zero would give the same single-tick strobe as one
  if (WR_CYC < 1 || WR_CYC > 255) begin : g_bad_wr_cyc
    $error("srmc_ctrl: write cycle count out of range");
  end
  if (RD_CYC < 1 || RD_CYC + SYNC_LAT > 255) begin : g_bad_rd_cyc
    $error("srmc_ctrl: read cycle count out of range");
  end

  // ****************************************
  // Input capture
  // ****************************************
  // Three stages; data accepted once stages two and three agree
  logic [`SRMC_DATA_W-1:0] dq_s1, dq_s2, dq_s3, dq_q;
  logic [`SRMC_DATA_W-1:0] next_dq_s1, next_dq_s2, next_dq_s3, next_dq_q;

  // Shift the pins in; pick up a settled value only
  always_comb begin
    next_dq_s1 = MEM_DQ_I;
    next_dq_s2 = dq_s1;
    next_dq_s3 = dq_s2;
    next_dq_q = (dq_s2 == dq_s3) ? dq_s3 : dq_q;
  end

  // Register the capture chain
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
      dq_q <= '0;
    end else begin
      dq_s1 <= next_dq_s1;
      dq_s2 <= next_dq_s2;
      dq_s3 <= next_dq_s3;
      dq_q <= next_dq_q;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  srmc_pkg::srmc_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [`SRMC_ADDR_W-1:0] next_addr;
  logic [`SRMC_DATA_W-1:0] wdata, next_wdata, next_rdata;
  logic ce_n, oe_n, we_n, dq_oe, rsp;
  logic next_ce_n, next_oe_n, next_we_n, next_dq_oe, next_rsp;

  // Read wait covers the access cycles plus the sync chain
  localparam int RD_WAIT = RD_CYC + SYNC_LAT;

  assign REQ_READY = (state == srmc_pkg::ST_IDLE);

  // Final tick of a wait; shared by sequencer and response
  function automatic logic last_tick(input logic [7:0] count);
    return count <= 8'h01;
  endfunction

  // Next-state and pin values
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr = MEM_ADDR;
    next_wdata = wdata;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_dq_oe = dq_oe;
    case (state)
      srmc_pkg::ST_IDLE: begin
        next_ce_n = 1'b1; // Deselected, device in standby
        next_oe_n = 1'b1;
        next_we_n = 1'b1;
        next_dq_oe = 1'b0;
        if (REQ_VALID) begin
          // Address and select change together
          next_addr = REQ.addr;
          next_wdata = REQ.wdata;
          next_ce_n = 1'b0;
          if (REQ.write) begin
            // OE kept high so device never drives
            next_we_n = 1'b0; // Overlap starts the write
            next_dq_oe = 1'b1;
            next_cnt = 8'(WR_CYC);
            next_state = srmc_pkg::ST_WRITE;
          end else begin
            next_oe_n = 1'b0; // Read with strobe high
            next_cnt = 8'(RD_WAIT);
            next_state = srmc_pkg::ST_READ;
          end
        end
      end
      srmc_pkg::ST_WRITE: begin
        // Data held across the whole overlap
        if (last_tick(cnt)) begin
          // Strobe rises first; select and data hold a cycle
          next_we_n = 1'b1;
          next_state = srmc_pkg::ST_DONE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      srmc_pkg::ST_READ: begin
        if (last_tick(cnt)) begin
          next_oe_n = 1'b1;
          next_ce_n = 1'b1; // Strobe already high
          next_state = srmc_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      srmc_pkg::ST_DONE: begin
        // Release data after strobe, zero hold met
        next_ce_n = 1'b1;
        next_dq_oe = 1'b0;
        next_state = srmc_pkg::ST_IDLE;
      end
      default: begin
        next_state = srmc_pkg::ST_IDLE;
      end
    endcase
  end

  // Register sequencer state and pins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= srmc_pkg::ST_IDLE;
      cnt <= 8'h00;
      MEM_ADDR <= '0;
      wdata <= '0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      MEM_ADDR <= next_addr;
      wdata <= next_wdata;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      dq_oe <= next_dq_oe;
    end
  end

  // ****************************************
  // Response
  // ****************************************
  // Read pulse and data on the final tick, write pulse in ST_DONE; data held until the next read
  always_comb begin
    next_rdata = RSP_RDATA;
    next_rsp = 1'b0;
    if (state == srmc_pkg::ST_READ && last_tick(cnt)) begin
      next_rdata = dq_q; // Settled byte from the capture chain returned
      next_rsp = 1'b1;
    end
    if (state == srmc_pkg::ST_DONE) begin
      next_rsp = 1'b1;
    end
  end

  // Register the response
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RSP_RDATA <= '0;
      rsp <= 1'b0;
    end else begin
      RSP_RDATA <= next_rdata;
      rsp <= next_rsp;
    end
  end

  // ****************************************
  // Pin outputs
  // ****************************************
  // All pins straight from flip-flops, no glitches on the strobes
  assign MEM_CE_N = ce_n;
  assign MEM_OE_N = oe_n;
  assign MEM_WE_N = we_n;
  assign MEM_DQ_O = wdata;
  assign MEM_DQ_OE = dq_oe;
  assign RSP_VALID = rsp;

endmodule // srmc_ctrl

// ==== src/srmc_params.svh ====
// Purpose: Constants for the static RAM host controller
// Assumes: 20 MHz system clock, 50 ns period
// Notes: Times in ns, cycle counts derived with rounding up
`ifndef SRMC_PARAMS_SVH
`define SRMC_PARAMS_SVH

// ****************************************
// Geometry and timing
// ****************************************
`define SRMC_ADDR_W 17
`define SRMC_DATA_W 8
`define SRMC_DEPTH 131072
`define SRMC_CLK_NS 50
// Write strobe low to device outputs released, slowest grade
`define SRMC_WR_HIGHZ_NS 7
// Data setup before the write-ending edge, slowest grade
`define SRMC_DATA_SETUP_NS 8
// Read access from select, slowest grade
`define SRMC_ACCESS_NS 15
`define SRMC_CEIL(t) (((t) + `SRMC_CLK_NS - 1) / `SRMC_CLK_NS)
`define SRMC_WR_CYC \
  `SRMC_CEIL(`SRMC_WR_HIGHZ_NS + `SRMC_DATA_SETUP_NS)
`define SRMC_RD_CYC `SRMC_CEIL(`SRMC_ACCESS_NS)

`endif

// ==== src/srmc_pkg.sv ====
// Purpose: Types for the static RAM host controller
// Assumes: Included parameters header
// Notes: Request carried as a packed struct
`include "srmc_params.svh"
package srmc_pkg;
  typedef struct packed {
    logic write;
    logic [`SRMC_ADDR_W-1:0] addr;
    logic [`SRMC_DATA_W-1:0] wdata;
  } srmc_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ = 4'b0100,
    ST_DONE = 4'b1000
  } srmc_state_t;
endpackage

// ==== verif/srmc_ram.sv ====
// Purpose: Behavioural static RAM
// Assumes: Zero-delay pins
// Notes: Idle bus shows inverted last value
`timescale 1ns/1ns
module srmc_ram (
  input wire logic [16:0] a, // Address
  input wire logic ce_n, // Select
  input wire logic oe_n, // Output enable
  input wire logic we_n, // Strobe
  input wire logic [7:0] d, // Bus level
  output logic [7:0] q // Device data
);
  logic [7:0] mem [131072];
  logic [7:0] last = 8'h00;
  logic drv;
  // Drive only on a plain read
  assign drv = !ce_n && !oe_n && we_n;
  // Overlap writes; first rise ends it
  always @* if (!ce_n && !we_n) mem[a] = d;
  always @* if (drv) last = mem[a];
  // Released bus never echoes stale data
  assign q = drv ? mem[a] : ~last;
endmodule // srmc_ram

// ==== verif/srmc_ctrl_checker.sv ====
// Purpose: Pin checks on the controller
// Assumes: Default one-cycle counts
// Notes: Bound to every controller
`timescale 1ns/1ns
module srmc_chk #(parameter int WR_CYC = 1, parameter int RD_CYC = 1) (
  input wire logic CLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic RSP_VALID, // Done
  input wire logic [16:0] MEM_ADDR, // Address
  input wire logic MEM_CE_N, // Select
  input wire logic MEM_OE_N, // Output enable
  input wire logic MEM_WE_N, // Strobe
  input wire logic [7:0] MEM_DQ_O, // Write data
  input wire logic MEM_DQ_OE // Host drives
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Strobe ends the write, select follows
  sequence s_wr_end;
    ##1 MEM_WE_N && !MEM_CE_N ##1 MEM_CE_N && !MEM_DQ_OE;
  endsequence
  a_wr_overlap: assert property (
    $fell(MEM_WE_N) |-> !MEM_CE_N && MEM_DQ_OE) else $error("wr start");
  a_wr_span: assert property (
    $fell(MEM_WE_N) |-> s_wr_end) else $error("wr span");
  a_wr_hold: assert property (
    $rose(MEM_WE_N) |-> MEM_DQ_OE && $stable(MEM_DQ_O)) else $error("hold");
  a_no_fight: assert property (
    MEM_DQ_OE |-> MEM_OE_N) else $error("contention");
  // Output enable held through the wait, then all released at once
  sequence s_rd_end;
    (!MEM_OE_N && MEM_WE_N && !MEM_CE_N)[*5]
    ##1 MEM_OE_N && MEM_CE_N && RSP_VALID;
  endsequence
  a_rd_window: assert property (
    $fell(MEM_OE_N) |-> s_rd_end) else $error("rd window");
  a_addr_steady: assert property (
    !MEM_CE_N && !$fell(MEM_CE_N) |-> $stable(MEM_ADDR)) else $error("addr");
endmodule // srmc_chk
bind srmc_ctrl srmc_chk #(.WR_CYC(WR_CYC), .RD_CYC(RD_CYC)) chk (.*);

// ==== verif/srmc_ctrl_test.sv ====
// Purpose: Controller bench
// Assumes: One-cycle default counts
// Notes: Inputs move 1 ns after the edge
`timescale 1ns/1ns
`include "srmc_params.svh"
module srmc_ctrl_test;
  logic CLK = 0, RST_N = 0, REQ_VALID = 0;
  srmc_pkg::srmc_req_t REQ = '0;
  logic REQ_READY, RSP_VALID, MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_DQ_OE;
  logic [7:0] RSP_RDATA, MEM_DQ_O, dev, q;
  logic [16:0] MEM_ADDR;
  wire logic [7:0] MEM_DQ_I = MEM_DQ_OE ? MEM_DQ_O : dev;
  int failures = 0, n_checks = 0, cyc = 0;
  always #25 CLK = ~CLK;
  srmc_ctrl dut (.*);
  srmc_ram ram (.a(MEM_ADDR), .ce_n(MEM_CE_N), .oe_n(MEM_OE_N),
    .we_n(MEM_WE_N), .d(MEM_DQ_I), .q(dev));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One request; edges after the take until the done pulse
  task automatic xfer(input logic w, input logic [16:0] a,
    input logic [7:0] d, output logic [7:0] rd);
    int n;
    n = 0;
    REQ_VALID = 1;
    REQ = '{write: w, addr: a, wdata: d};
    while (REQ_READY !== 1'b1) @(posedge CLK) #1;
    @(posedge CLK) #1 REQ_VALID = 0;
    while (RSP_VALID !== 1'b1 && n < 20) @(posedge CLK) #1 n++;
    chk(8'(n), w ? 8'(`SRMC_WR_CYC + 1) : 8'(`SRMC_RD_CYC + 4));
    rd = RSP_RDATA;
  endtask
  task automatic t_edges;
    xfer(1, 17'h00000, 8'h3c, q);
    xfer(1, 17'h1ffff, 8'hc3, q);
    xfer(0, 17'h00000, 8'h00, q);
    chk(q, 8'h3c);
    xfer(0, 17'h1ffff, 8'h00, q);
    chk(q, 8'hc3);
  endtask
  task automatic t_overwrite;
    xfer(1, 17'h0aaaa, 8'h11, q);
    xfer(1, 17'h0aaaa, 8'hee, q);
    xfer(0, 17'h0aaaa, 8'h00, q);
    chk(q, 8'hee);
  endtask
  // Walking address bit catches shorted or dropped lines
  task automatic t_walk;
    for (int i = 0; i < 17; i++) begin
      xfer(1, 17'(1 << i), 8'(i + 64), q);
    end
    for (int i = 0; i < 17; i++) begin
      xfer(0, 17'(1 << i), 8'h00, q);
      chk(q, 8'(i + 64));
    end
  endtask
  // Mid-run reset: pins deselect, read data clears, contents survive
  task automatic t_reset;
    xfer(1, 17'h05555, 8'h5a, q);
    RST_N = 0;
    #1 chk({4'h0, MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_DQ_OE}, 8'h0e);
    chk(RSP_RDATA, 8'h00);
    @(posedge CLK) #1 RST_N = 1;
    xfer(0, 17'h05555, 8'h00, q);
    chk(q, 8'h5a);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge CLK);
    #1 chk({4'h0, MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_DQ_OE}, 8'h0e);
    RST_N = 1;
    t_edges();
    t_overwrite();
    t_walk();
    t_reset();
    stop_test();
  end
endmodule // srmc_ctrl_test
